/* File: rtl/trigger_pulse_queue.sv */
/*
  Trigger pulse queue with output rate limiter for four camera channels,
  with APB register access, bypass routing and cross-channel selection.
  Assumes APB master and trigger inputs on pclk; no interrupt logic.
*/
`default_nettype none

module trigger_pulse_queue #(
  parameter int NCAM = trig_queue_pkg::NCAM,
  parameter int NIN = trig_queue_pkg::NIN
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External trigger inputs.
  input wire logic [NIN-1:0] ext_in,
  // Trigger outputs per channel.
  output logic [NCAM-1:0] cam_trig,
  output logic [NCAM-1:0] front_out,
  output logic [NCAM-1:0] lost_event
);

  localparam int OW = trig_queue_pkg::OCC_W;
  localparam logic [OW-1:0] CAP = OW'(trig_queue_pkg::QUEUE_CAP);

  // Returns whether the active edge of an input occurred.
  function automatic logic edge_of(input logic cur, input logic prev,
                                   input logic fall);
    edge_of = fall ? (prev & ~cur) : (cur & ~prev);
  endfunction : edge_of

  // Picks an output source; bypass codes skip the rate limiter.
  function automatic logic pick(input logic [2:0] sel, input logic own,
                                input logic other, input logic lvl,
                                input logic rise, input logic fall);
    case (sel)
      trig_queue_pkg::SRC_OWN: pick = own;
      trig_queue_pkg::SRC_OTHER: pick = other;
      trig_queue_pkg::SRC_PASS: pick = lvl;
      trig_queue_pkg::SRC_RISE: pick = rise;
      trig_queue_pkg::SRC_FALL: pick = fall;
      default: pick = 1'b0;
    endcase
  endfunction : pick

  // Channel state, one element per camera channel.
  trig_queue_pkg::ctrl_type ctrl_ff [NCAM];
  trig_queue_pkg::outsel_type outsel_ff [NCAM];
  trig_queue_pkg::run_type run_ff [NCAM];
  trig_queue_pkg::run_type nxt_run [NCAM];
  logic [31:0] period_ff [NCAM];
  logic [15:0] seq_ff [NCAM];
  logic [15:0] idx_ff [NCAM];
  logic [15:0] nxt_idx [NCAM];
  logic [31:0] gap_ff [NCAM];
  logic [OW-1:0] occ_ff [NCAM];
  logic [OW-1:0] nxt_occ [NCAM];
  logic [OW-1:0] cap_eff [NCAM];
  logic [OW-1:0] space [NCAM];
  logic [OW-1:0] add [NCAM];
  logic [31:0] rd_word [NCAM];
  logic [NCAM-1:0] pulse_ff;
  logic [NCAM-1:0] viol_ff;
  logic [NCAM-1:0] lost_ff;
  logic [NCAM-1:0] emit;
  logic [NCAM-1:0] done;
  logic [NCAM-1:0] gap_ok;
  logic [NCAM-1:0] blocked;
  logic [NCAM-1:0] abort;
  logic [NCAM-1:0] ext_ev;
  logic [NCAM-1:0] ext_lost;
  logic [NCAM-1:0] in_lvl;
  logic [NCAM-1:0] in_rise;
  logic [NCAM-1:0] in_fall;
  logic [NIN-1:0] in_prev_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [NCAM-1:0] cam_ff;
  logic [NCAM-1:0] front_ff;

  // Bus decode; the access phase always completes one cycle after setup.
  wire logic setup = psel & ~penable;
  wire logic [4:0] ofs = paddr[4:0];
  wire logic [1:0] bus_ch = paddr[6:5];
  wire logic addr_ok = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0);
  wire logic strb_ok = ~pwrite | (pstrb == 4'hF);
  wire logic wr_en = psel & penable & pready_ff & pwrite & addr_ok & strb_ok;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cam_trig = cam_ff;
  assign front_out = front_ff;
  assign lost_event = lost_ff;

  // Read data is captured in the setup cycle so it is a flop in access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      in_prev_ff <= '0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~(addr_ok & strb_ok);
      prdata_ff <= (setup & addr_ok & ~pwrite) ? rd_word[bus_ch] :
                   32'h0000_0000;
      in_prev_ff <= ext_in;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCAM; g++) begin : gen_ch
      wire logic sel_wr = wr_en && (bus_ch == 2'(g));
      wire logic accepting = (run_ff[g] == trig_queue_pkg::RUN_ACTIVE);
      wire logic [1:0] mode = ctrl_ff[g].mode;
      wire logic cur = ext_in[ctrl_ff[g].in_sel];
      wire logic prev = in_prev_ff[ctrl_ff[g].in_sel];
      wire logic edge_hit = edge_of(cur, prev, ctrl_ff[g].polarity);
      wire logic sync_hit = (g > 0) ? pulse_ff[0] : 1'b0;
      wire logic queued = ctrl_ff[g].queue_on;
      wire logic [15:0] seq_eff = (seq_ff[g] == 16'h0000) ? 16'h0001 :
                                  seq_ff[g];
      wire logic last = (idx_ff[g] == seq_eff - 16'h0001);
      wire logic ext_take;
      wire logic sw_wr;
      wire logic [OW-1:0] sw_add;
      wire logic cmd_wr = sel_wr && (ofs == trig_queue_pkg::OFS_RUN);
      wire logic [1:0] cmd = pwdata[1:0];
      wire trig_queue_pkg::ctrl_type wr_ctrl = pwdata[5:0];
      wire logic bad_sync = (g == 0) &&
                            (wr_ctrl.mode == trig_queue_pkg::MODE_SYNC);

      // Source events; several channels may watch the same input.
      assign ext_ev[g] = accepting &&
        ((mode == trig_queue_pkg::MODE_EXTERNAL) ? edge_hit :
         (mode == trig_queue_pkg::MODE_SYNC) ? sync_hit : 1'b0);
      assign in_lvl[g] = cur;
      assign in_rise[g] = edge_of(cur, prev, 1'b0);
      assign in_fall[g] = edge_of(cur, prev, 1'b1);

      // Without queuing the capacity is a single in-flight request.
      assign cap_eff[g] = queued ? CAP : OW'(1);
      assign space[g] = cap_eff[g] - occ_ff[g];
      assign blocked[g] = (occ_ff[g] >= cap_eff[g]);
      assign gap_ok[g] = (gap_ff[g] >= period_ff[g]);
      assign ext_take = ext_ev[g] && (queued ? (space[g] != '0) :
                        ((occ_ff[g] == '0) && gap_ok[g]));
      assign ext_lost[g] = ext_ev[g] & ~ext_take;
      assign sw_wr = sel_wr && (ofs == trig_queue_pkg::OFS_SWREQ) &&
                     accepting && (mode == trig_queue_pkg::MODE_SOFTWARE) &&
                     !blocked[g];
      // A count beyond the free space is clipped to what fits.
      assign sw_add = ((pwdata[31:OW] != '0) ||
                       (pwdata[OW-1:0] > space[g])) ? space[g] :
                      pwdata[OW-1:0];
      assign add[g] = ext_take ? OW'(1) : (sw_wr ? sw_add : '0);
      assign abort[g] = cmd_wr && ((cmd == trig_queue_pkg::CMD_ABORT) ||
                                   (cmd == trig_queue_pkg::CMD_STOP));
      // A queued request is emitted once the spacing has elapsed.
      assign emit[g] = (run_ff[g] != trig_queue_pkg::RUN_STOPPED) &&
                       (occ_ff[g] != '0) && gap_ok[g] && !abort[g];
      assign done[g] = emit[g] & last;
      assign nxt_occ[g] = abort[g] ? '0 :
                          occ_ff[g] + add[g] - OW'(done[g]);
      assign nxt_idx[g] = (abort[g] || done[g]) ? 16'h0000 :
                          (emit[g] ? idx_ff[g] + 16'h0001 : idx_ff[g]);

      // Run state: drain keeps emitting until the queue is empty.
      always_comb begin
        nxt_run[g] = run_ff[g];
        if (cmd_wr) begin
          case (cmd)
            trig_queue_pkg::CMD_START: nxt_run[g] = trig_queue_pkg::RUN_ACTIVE;
            trig_queue_pkg::CMD_DRAIN: nxt_run[g] = trig_queue_pkg::RUN_DRAIN;
            default: nxt_run[g] = trig_queue_pkg::RUN_STOPPED;
          endcase
        end
        if ((nxt_run[g] == trig_queue_pkg::RUN_DRAIN) &&
            (nxt_occ[g] == '0)) begin
          nxt_run[g] = trig_queue_pkg::RUN_STOPPED;
        end
      end

      // Register readback.
      assign rd_word[g] =
        (ofs == trig_queue_pkg::OFS_CTRL) ? {26'h0, ctrl_ff[g]} :
        (ofs == trig_queue_pkg::OFS_RUN) ? {30'h0, run_ff[g]} :
        (ofs == trig_queue_pkg::OFS_PERIOD) ? period_ff[g] :
        (ofs == trig_queue_pkg::OFS_SEQ) ? {16'h0, seq_ff[g]} :
        (ofs == trig_queue_pkg::OFS_STATUS) ?
          {29'h0, occ_ff[g] != '0, viol_ff[g], blocked[g]} :
        (ofs == trig_queue_pkg::OFS_FILL) ?
          {5'h00, space[g], 5'h00, occ_ff[g]} :
        (ofs == trig_queue_pkg::OFS_OUTSEL) ? {22'h0, outsel_ff[g]} :
        32'h0000_0000;

      // Configuration written by software steers the channel.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_ff[g] <= trig_queue_pkg::CTRL_RST;
          outsel_ff[g] <= trig_queue_pkg::OUTSEL_RST;
          period_ff[g] <= trig_queue_pkg::PERIOD_RST;
          seq_ff[g] <= trig_queue_pkg::SEQ_RST;
        end else if (sel_wr) begin
          if (ofs == trig_queue_pkg::OFS_CTRL) begin
            ctrl_ff[g] <= bad_sync ?
              {wr_ctrl.in_sel, wr_ctrl.queue_on, wr_ctrl.polarity,
               trig_queue_pkg::MODE_SOFTWARE} : wr_ctrl;
          end
          if (ofs == trig_queue_pkg::OFS_OUTSEL) begin
            outsel_ff[g] <= pwdata[9:0];
          end
          if (ofs == trig_queue_pkg::OFS_PERIOD) begin
            period_ff[g] <= pwdata;
          end
          if (ofs == trig_queue_pkg::OFS_SEQ) begin
            seq_ff[g] <= pwdata[15:0];
          end
        end
      end

      // Queue, sequence position and spacing counter.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          run_ff[g] <= trig_queue_pkg::RUN_STOPPED;
          occ_ff[g] <= '0;
          idx_ff[g] <= 16'h0000;
          gap_ff[g] <= trig_queue_pkg::GAP_RST;
          pulse_ff[g] <= 1'b0;
          lost_ff[g] <= 1'b0;
          viol_ff[g] <= 1'b0;
        end else begin
          run_ff[g] <= nxt_run[g];
          occ_ff[g] <= nxt_occ[g];
          idx_ff[g] <= nxt_idx[g];
          gap_ff[g] <= emit[g] ? 32'h0000_0001 :
                       (gap_ok[g] ? gap_ff[g] : gap_ff[g] + 32'h0000_0001);
          pulse_ff[g] <= emit[g];
          lost_ff[g] <= ext_lost[g];
          // Set wins over the write-one clear.
          viol_ff[g] <= ext_lost[g] | (viol_ff[g] & ~(sel_wr &&
                        (ofs == trig_queue_pkg::OFS_STATUS) &&
                        pwdata[trig_queue_pkg::ST_VIOL]));
        end
      end

      // Output selection, including bypass and cross-channel sources.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cam_ff[g] <= 1'b0;
          front_ff[g] <= 1'b0;
        end else begin
          cam_ff[g] <= pick(outsel_ff[g].cam_sel, pulse_ff[g],
                            pulse_ff[outsel_ff[g].cam_src], in_lvl[g],
                            in_rise[g], in_fall[g]);
          front_ff[g] <= pick(outsel_ff[g].front_sel, pulse_ff[g],
                              pulse_ff[outsel_ff[g].front_src], in_lvl[g],
                              in_rise[g], in_fall[g]);
        end
      end
    end
  endgenerate

  // Helper: cycles since channel zero's previous pulse.
  logic [31:0] since_ff;
  logic seen_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_ff <= 32'h0000_0000;
      seen_ff <= 1'b0;
    end else begin
      since_ff <= pulse_ff[0] ? 32'h0000_0001 : since_ff + 32'h0000_0001;
      seen_ff <= seen_ff | pulse_ff[0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  occ_cap_a: assert property (occ_ff[0] <= CAP)
    else $error("Occupancy beyond capacity.");
  pulse_spacing_a: assert property (
    (pulse_ff[0] && seen_ff && $stable(period_ff[0])) |->
      (since_ff >= period_ff[0]))
    else $error("Output pulses closer than the minimum period.");
  abort_clear_a: assert property (
    (psel && penable && pready && pwrite && paddr == 12'h004 &&
     pstrb == 4'hF && pwdata[1:0] == 2'h3) |=>
      (occ_ff[0] == '0) ##1 (!pulse_ff[0] [*3]))
    else $error("Abort left pulses pending.");
  blocked_full_a: assert property (
    ctrl_ff[0].queue_on |-> (blocked[0] == (occ_ff[0] == CAP)))
    else $error("Blocked while queue not full.");
  drain_refuse_a: assert property (
    (run_ff[0] == trig_queue_pkg::RUN_DRAIN) |-> (add[0] == '0))
    else $error("Input accepted during drain.");
  fill_drop_a: assert property (
    ((occ_ff[0] < $past(occ_ff[0])) && !$past(abort[0])) |->
      (pulse_ff[0] && $past(idx_ff[0]) == $past(seq_ff[0]) - 16'h0001 ||
       pulse_ff[0] && $past(seq_ff[0]) == 16'h0000))
    else $error("Occupancy fell before the last pulse.");
  lost_full_a: assert property (
    (lost_ff[0] && $past(ctrl_ff[0].queue_on)) |->
      ($past(occ_ff[0]) == CAP))
    else $error("Lost event while queue had space.");
  lost_early_a: assert property (
    (lost_ff[0] && !$past(ctrl_ff[0].queue_on)) |->
      ($past(occ_ff[0]) != '0 || !$past(gap_ok[0])))
    else $error("Input dropped although the channel was free.");
  direct_pass_a: assert property (
    (ext_ev[0] && occ_ff[0] == '0 && gap_ok[0] && !abort[0]) |->
      ##2 (pulse_ff[0] && (occ_ff[0] != '0 || seq_ff[0] <= 16'h0001)))
    else $error("Input into empty queue not passed at once.");
  sync_source_a: assert property (
    (pulse_ff[0] && ctrl_ff[1].mode == trig_queue_pkg::MODE_SYNC &&
     run_ff[1] == trig_queue_pkg::RUN_ACTIVE) |-> ext_ev[1])
    else $error("Secondary channel ignored the first channel's pulse.");

  // Channel zero has no earlier channel, so it may never follow one.
  sync_first_a: assert property (
    ctrl_ff[0].mode != trig_queue_pkg::MODE_SYNC)
    else $error("Channel zero took the synchronized mode.");

  // A request written into a full queue must change nothing.
  blocked_ignore_a: assert property (
    (psel && penable && pwrite && paddr == 12'h010 && blocked[0] &&
     !done[0]) |=> (occ_ff[0] == $past(occ_ff[0])))
    else $error("Request accepted while blocked.");

  // A level held high must not count as a second event.
  edge_once_a: assert property (
    ext_ev[0] |=> !ext_ev[0])
    else $error("One input edge gave two events.");

  // A bypassed level skips the queue and shows one cycle later.
  bypass_level_a: assert property (
    (outsel_ff[3].cam_sel == trig_queue_pkg::SRC_PASS) |=>
      (cam_ff[3] == $past(in_lvl[3])))
    else $error("Bypass output did not follow its input.");

  queue_burst_c: cover property (occ_ff[0] >= 2 ##[1:200] pulse_ff[0]);
  overflow_c: cover property (lost_ff[0] && ctrl_ff[0].queue_on);
  drain_end_c: cover property ((run_ff[0] == trig_queue_pkg::RUN_DRAIN)
    ##1 (run_ff[0] == trig_queue_pkg::RUN_STOPPED));
  sync_chain_c: cover property (pulse_ff[0] ##2 pulse_ff[1]);
  bypass_c: cover property (cam_ff[3] &&
    outsel_ff[3].cam_sel == trig_queue_pkg::SRC_FALL);

endmodule : trigger_pulse_queue

`default_nettype wire

/* File: rtl/trig_queue_pkg.sv */
/*
  Shared constants, field layouts and types of the trigger pulse queue.
  Assumes a single 250 MHz APB clock domain and synchronous trigger inputs.
*/
// Behaviour
// - Software and external requests are queued and released no faster than programmed.
// - With queuing on, software is blocked only while the queue is full.
// - Writing a count to the request register enqueues that many requests, or as many as fit in the free space.
// - Queue holds 2040 entries; space left is capacity minus occupancy.
// - Occupancy is readable and drops only after a sequence's last pulse, or to zero on a stop or abort command.
// - Drain halt refuses new inputs but finishes every queued pulse.
// - Abort halt cancels pulse generation at once, dropping queued pulses.
// - External inputs are queued only while the queue mode bit is on.
// - Queued pulses are spaced by at least the minimum output period.
// - An input into an empty, rested queue goes straight to the output.
// - With queuing, lost event and violation flag rise only on overflow.
// - Without queuing, an early external input is dropped and reported.
// - External inputs are edge events; polarity picks rising or falling.
// - Output selectors can bypass an input, or its edges, to an output.
// - Four camera trigger channels; several may share one input.
// - Synchronized mode feeds a secondary channel from channel zero's pulses.
// - Synchronized mode is refused for the first channel.
// - An output selector may take another channel's pulse as its source.
// - Minimum output spacing is the reciprocal of the maximum output rate.
// - A request written while blocked is ignored and not enqueued.
`default_nettype none

package trig_queue_pkg;

  localparam int NCAM = 4;
  localparam int NIN = 4;
  localparam int QUEUE_CAP = 2040;
  localparam int OCC_W = 11;
  localparam int CLK_HZ = 250000000;

  // Per-channel register offsets; channel n sits at n * 32 bytes.
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_RUN = 5'h04;
  localparam logic [4:0] OFS_PERIOD = 5'h08;
  localparam logic [4:0] OFS_SEQ = 5'h0C;
  localparam logic [4:0] OFS_SWREQ = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_FILL = 5'h18;
  localparam logic [4:0] OFS_OUTSEL = 5'h1C;

  // Source modes held in the control register.
  localparam logic [1:0] MODE_SOFTWARE = 2'h0;
  localparam logic [1:0] MODE_EXTERNAL = 2'h1;
  localparam logic [1:0] MODE_SYNC = 2'h2;

  // Run commands written to the run register.
  localparam logic [1:0] CMD_STOP = 2'h0;
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_DRAIN = 2'h2;
  localparam logic [1:0] CMD_ABORT = 2'h3;

  // Output selector source codes.
  localparam logic [2:0] SRC_OWN = 3'h0;
  localparam logic [2:0] SRC_OTHER = 3'h1;
  localparam logic [2:0] SRC_PASS = 3'h2;
  localparam logic [2:0] SRC_RISE = 3'h3;
  localparam logic [2:0] SRC_FALL = 3'h4;

  // Status bit positions and fill field position.
  localparam int ST_BLOCKED = 0;
  localparam int ST_VIOL = 1;
  localparam int ST_BUSY = 2;
  localparam int FILL_SPACE_LSB = 16;

  // Reset values.
  localparam logic [31:0] PERIOD_RST = 32'h0000_0001;
  localparam logic [15:0] SEQ_RST = 16'h0001;
  localparam logic [31:0] GAP_RST = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {RUN_STOPPED, RUN_ACTIVE, RUN_DRAIN} run_type;

  typedef struct packed {
    logic [1:0] in_sel;
    logic queue_on;
    logic polarity;
    logic [1:0] mode;
  } ctrl_type;

  typedef struct packed {
    logic [1:0] front_src;
    logic [2:0] front_sel;
    logic [1:0] cam_src;
    logic [2:0] cam_sel;
  } outsel_type;

  localparam ctrl_type CTRL_RST = 6'h00;
  localparam outsel_type OUTSEL_RST = 10'h000;

endpackage : trig_queue_pkg

`default_nettype wire

/* File: verification/trig_source.sv */
/*
  External trigger source model: each fire request gives one clean pulse.
  Assumes fire is driven on the rising edge of pclk by the bench.
*/
`default_nettype none

module trig_source #(
  parameter int WIDTH = 4,
  parameter int HOLD = 3
) (
  // Clock.
  input wire logic pclk,
  // Requests and lines.
  input wire logic [WIDTH-1:0] fire,
  output logic [WIDTH-1:0] ext_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int left [WIDTH];

  // Every pulse is a full rise and fall, so either edge can be used.
  always @(posedge pclk) begin
    for (int i = 0; i < WIDTH; i++) begin
      if (fire[i]) begin
        left[i] = HOLD;
      end else if (left[i] > 0) begin
        left[i] = left[i] - 1;
      end
      ext_in[i] <= (left[i] > 0);
    end
  end

  initial begin
    ext_in = '0;
    for (int i = 0; i < WIDTH; i++) left[i] = 0;
  end
endmodule : trig_source

`default_nettype wire

/* File: verification/trigger_pulse_queue_test.sv */
/*
  Self-checking bench of the trigger pulse queue over APB.
  Assumes one pclk domain and the trig_source model on the inputs.
*/
`default_nettype none

module trigger_pulse_queue_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 3;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] ext_in;
  logic [3:0] fire = 4'h0;
  logic [3:0] cam_trig;
  logic [3:0] front_out;
  logic [3:0] lost_event;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int ccnt [4];
  int fcnt [4];
  int lcnt [4];
  int last [4];
  int gap [4];
  logic [31:0] rd;
  logic er;
  trig_queue_pkg::outsel_type osel;

  trigger_pulse_queue dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_in(ext_in), .cam_trig(cam_trig), .front_out(front_out),
    .lost_event(lost_event));
  trig_source #(.WIDTH(4), .HOLD(HOLD)) src (.pclk(pclk), .fire(fire),
    .ext_in(ext_in));

  always #2 pclk = ~pclk;

  // Count output cycles and the smallest spacing seen per channel.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) begin
      if (cam_trig[i] === 1'b1) begin
        ccnt[i] = ccnt[i] + 1;
        if (cyc - last[i] < gap[i]) gap[i] = cyc - last[i];
        last[i] = cyc;
      end
      if (front_out[i] === 1'b1) fcnt[i] = fcnt[i] + 1;
      if (lost_event[i] === 1'b1) lcnt[i] = lcnt[i] + 1;
    end
  end

  task automatic clr();
    for (int i = 0; i < 4; i++) begin
      ccnt[i] = 0;
      fcnt[i] = 0;
      lcnt[i] = 0;
      last[i] = -1000;
      gap[i] = 1000;
    end
  endtask : clr

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s exp %h got %h", name, exp, got);
    end
  endtask : check

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] ad(input int ch, input logic [4:0] o);
    return 12'(ch * 32) + {7'h00, o};
  endfunction : ad

  task automatic wr(input int ch, input logic [4:0] o, input logic [31:0] d);
    apb(1'b1, ad(ch, o), d);
  endtask : wr

  task automatic rdc(input int ch, input logic [4:0] o,
                     input logic [31:0] exp);
    apb(1'b0, ad(ch, o), 32'h0000_0000);
    check("register", exp, rd);
  endtask : rdc

  task automatic pulse(input int line);
    @(posedge pclk);
    fire[line] <= 1'b1;
    @(posedge pclk);
    fire[line] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : pulse

  task automatic t_reset();
    rdc(0, trig_queue_pkg::OFS_CTRL, 32'h0000_0000);
    rdc(0, trig_queue_pkg::OFS_RUN, 32'h0000_0000);
    rdc(0, trig_queue_pkg::OFS_PERIOD, 32'h0000_0001);
    rdc(0, trig_queue_pkg::OFS_SEQ, 32'h0000_0001);
    rdc(0, trig_queue_pkg::OFS_FILL, 32'h0001_0000);
    rdc(0, trig_queue_pkg::OFS_OUTSEL, 32'h0000_0000);
    apb(1'b0, 12'h080, 32'h0000_0000);
    check("unmapped error", 32'h1, {31'h0, er});
    pstrb <= 4'h3;
    wr(0, trig_queue_pkg::OFS_PERIOD, 32'h0000_0009);
    check("strobe error", 32'h1, {31'h0, er});
    pstrb <= 4'hF;
    rdc(0, trig_queue_pkg::OFS_PERIOD, 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset

  task automatic t_queue();
    wr(0, trig_queue_pkg::OFS_PERIOD, 32'h0000_0004);
    wr(0, trig_queue_pkg::OFS_CTRL, 32'h0000_0008);
    wr(0, trig_queue_pkg::OFS_RUN, 32'h0000_0001);
    clr();
    wr(0, trig_queue_pkg::OFS_SWREQ, 32'h0000_0003);
    repeat (40) @(posedge pclk);
    check("pulses", 32'd3, 32'(ccnt[0]));
    check("spacing ok", 32'h1, {31'h0, gap[0] >= 4});
    rdc(0, trig_queue_pkg::OFS_FILL, 32'h07F8_0000);
    $display("test queue done");
  endtask : t_queue

  task automatic t_seq();
    int n;
    n = 0;
    wr(0, trig_queue_pkg::OFS_PERIOD, 32'h0000_0008);
    wr(0, trig_queue_pkg::OFS_SEQ, 32'h0000_0002);
    clr();
    wr(0, trig_queue_pkg::OFS_SWREQ, 32'h0000_0001);
    while (ccnt[0] < 1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    rdc(0, trig_queue_pkg::OFS_FILL, 32'h07F7_0001);
    repeat (30) @(posedge pclk);
    check("seq pulses", 32'd2, 32'(ccnt[0]));
    rdc(0, trig_queue_pkg::OFS_FILL, 32'h07F8_0000);
    $display("test sequence done");
  endtask : t_seq

  task automatic t_full();
    wr(0, trig_queue_pkg::OFS_PERIOD, 32'h0000_0032);
    wr(0, trig_queue_pkg::OFS_SWREQ, 32'h0000_0834);
    rdc(0, trig_queue_pkg::OFS_FILL, 32'h0000_07F8);
    rdc(0, trig_queue_pkg::OFS_STATUS, 32'h0000_0005);
    wr(0, trig_queue_pkg::OFS_SWREQ, 32'h0000_0001);
    rdc(0, trig_queue_pkg::OFS_FILL, 32'h0000_07F8);
    wr(0, trig_queue_pkg::OFS_CTRL, 32'h0000_0019);
    clr();
    pulse(1);
    check("full lost", 32'd1, 32'(lcnt[0]));
    wr(0, trig_queue_pkg::OFS_CTRL, 32'h0000_0008);
    wr(0, trig_queue_pkg::OFS_RUN, 32'h0000_0003);
    clr();
    rdc(0, trig_queue_pkg::OFS_FILL, 32'h07F8_0000);
    repeat (120) @(posedge pclk);
    check("after abort", 32'd0, 32'(ccnt[0]));
    rdc(0, trig_queue_pkg::OFS_RUN, 32'h0000_0000);
    $display("test full and abort done");
  endtask : t_full

  task automatic t_drain();
    wr(0, trig_queue_pkg::OFS_SEQ, 32'h0000_0001);
    wr(0, trig_queue_pkg::OFS_PERIOD, 32'h0000_0014);
    wr(0, trig_queue_pkg::OFS_RUN, 32'h0000_0001);
    clr();
    wr(0, trig_queue_pkg::OFS_SWREQ, 32'h0000_0003);
    wr(0, trig_queue_pkg::OFS_RUN, 32'h0000_0002);
    wr(0, trig_queue_pkg::OFS_SWREQ, 32'h0000_0001);
    repeat (100) @(posedge pclk);
    check("drained", 32'd3, 32'(ccnt[0]));
    check("drain spacing", 32'h1, {31'h0, gap[0] >= 20});
    rdc(0, trig_queue_pkg::OFS_RUN, 32'h0000_0000);
    $display("test drain done");
  endtask : t_drain

  task automatic t_ext();
    wr(0, trig_queue_pkg::OFS_PERIOD, 32'h0000_0014);
    wr(0, trig_queue_pkg::OFS_CTRL, 32'h0000_0011);
    wr(0, trig_queue_pkg::OFS_RUN, 32'h0000_0001);
    clr();
    pulse(1);
    pulse(1);
    repeat (40) @(posedge pclk);
    check("no queue pulses", 32'd1, 32'(ccnt[0]));
    check("no queue lost", 32'd1, 32'(lcnt[0]));
    rdc(0, trig_queue_pkg::OFS_STATUS, 32'h0000_0002);
    wr(0, trig_queue_pkg::OFS_STATUS, 32'h0000_0002);
    rdc(0, trig_queue_pkg::OFS_STATUS, 32'h0000_0000);
    wr(0, trig_queue_pkg::OFS_CTRL, 32'h0000_001D);
    clr();
    pulse(1);
    pulse(1);
    repeat (60) @(posedge pclk);
    check("queued pulses", 32'd2, 32'(ccnt[0]));
    check("queued lost", 32'd0, 32'(lcnt[0]));
    check("queued spacing", 32'h1, {31'h0, gap[0] >= 20});
    rdc(0, trig_queue_pkg::OFS_STATUS, 32'h0000_0000);
    $display("test external done");
  endtask : t_ext

  task automatic t_route();
    wr(0, trig_queue_pkg::OFS_CTRL, 32'h0000_0002);
    rdc(0, trig_queue_pkg::OFS_CTRL, 32'h0000_0000);
    wr(0, trig_queue_pkg::OFS_CTRL, 32'h0000_0008);
    wr(0, trig_queue_pkg::OFS_PERIOD, 32'h0000_0004);
    wr(0, trig_queue_pkg::OFS_RUN, 32'h0000_0001);
    wr(1, trig_queue_pkg::OFS_CTRL, 32'h0000_0002);
    wr(1, trig_queue_pkg::OFS_OUTSEL, 32'h0000_0000);
    wr(1, trig_queue_pkg::OFS_RUN, 32'h0000_0001);
    wr(3, trig_queue_pkg::OFS_CTRL, 32'h0000_0020);
    // Walk the three bypass codes; a level follows the whole pulse.
    for (int k = 0; k < 3; k++) begin
      osel = trig_queue_pkg::OUTSEL_RST;
      osel.cam_sel = trig_queue_pkg::SRC_PASS + 3'(k);
      osel.front_sel = trig_queue_pkg::SRC_OTHER;
      wr(3, trig_queue_pkg::OFS_OUTSEL, 32'(osel));
      clr();
      wr(0, trig_queue_pkg::OFS_SWREQ, 32'h0000_0002);
      pulse(2);
      repeat (30) @(posedge pclk);
      check("bypass", (k == 0) ? 32'(HOLD) : 32'd1, 32'(ccnt[3]));
      check("sync pulses", 32'd2, 32'(ccnt[1]));
      check("other pulses", 32'd2, 32'(fcnt[3]));
    end
    $display("test routing done");
  endtask : t_route

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Watchdog sized well above the expected run of under a thousand cycles.
  initial begin
    #200000;
    err_count++;
    results();
  end

  initial begin
    clr();
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_queue();
    t_seq();
    t_full();
    t_drain();
    t_ext();
    t_route();
    results();
  end
endmodule : trigger_pulse_queue_test

`default_nettype wire
